// File: design/usir_ir_codec.sv
// infrared pulse encoder and falling-edge decoder
`timescale 1ns/10ps
`default_nettype none
module usir_ir_codec
   import usir_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // timing from the baud generator
   input wire logic enable_in,
   input wire logic tick16_in,
   input wire logic [3:0] phase_in,
   // transmit side
   input wire logic enc_bit_in,
   input wire logic tx_pol_in,
   output logic enc_out,
   // receive side, already synchronised
   input wire logic rx_in,
   input wire logic rx_pol_in,
   output logic dec_out
);
   typedef struct packed {
      logic enc;
      logic dec;
      logic rx_d;
      logic pend;
      logic [3:0] cnt;
   } usir_codec_s;

   usir_codec_s q, n;
   logic rx_norm;
   logic rx_fall;
   logic pulse;

   assign rx_norm = rx_in ^ rx_pol_in;
   assign rx_fall = q.rx_d & ~rx_norm;
   // a zero bit gets a pulse in periods 7..9, a one bit stays low
   assign pulse = ~enc_bit_in && phase_in >= USIR_IR_PULSE_FIRST
      && phase_in <= USIR_IR_PULSE_LAST;

   always_comb
   begin
      n = q;
      n.rx_d = rx_norm;
      n.enc = pulse ^ tx_pol_in;
      if (!enable_in)
      begin
         n.enc = tx_pol_in;
         n.dec = 1'b1;
         n.pend = 1'b0;
         n.cnt = 4'h0;
      end
      else
      begin
         if (rx_fall)
         begin
            if (q.dec)
            begin
               n.dec = 1'b0;
               n.cnt = 4'h0;
            end
            else
            begin
               n.pend = 1'b1;
            end
         end
         if (!q.dec && tick16_in)
         begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == USIR_IR_HOLD_LAST)
            begin
               // an edge seen during the window keeps the line low another 16
               n.cnt = 4'h0;
               n.pend = rx_fall;
               n.dec = ~(q.pend | rx_fall);
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         q <= '{enc: 1'b0, dec: 1'b1, rx_d: 1'b1, pend: 1'b0, cnt: 4'h0};
      end
      else
      begin
         q <= n;
      end
   end

   assign enc_out = q.enc;
   assign dec_out = q.dec;
endmodule // usir_ir_codec
`default_nettype wire

// File: design/usir_pkg.sv
// shared constants for the synchronous slave and infrared serial block
package usir_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] USIR_CTRL_OFF = 8'h00;
   localparam logic [7:0] USIR_BAUD_OFF = 8'h04;
   localparam logic [7:0] USIR_BRG_OFF = 8'h08;
   localparam logic [7:0] USIR_TXDATA_OFF = 8'h0C;
   localparam logic [7:0] USIR_RXDATA_OFF = 8'h10;
   localparam logic [7:0] USIR_STATUS_OFF = 8'h14;
   localparam logic [7:0] USIR_IRQEN_OFF = 8'h18;
   // control register fields
   localparam int USIR_CTRL_SERIAL_PORT_ENABLE_BIT = 0;
   localparam int USIR_CTRL_SYNC_BIT = 1;
   localparam int USIR_CTRL_CLOCK_SOURCE_SELECT_BIT = 2;
   localparam int USIR_CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT = 3;
   localparam int USIR_CTRL_SINGLE_RECEIVE_ENABLE_BIT = 4;
   localparam int USIR_CTRL_TXEN_BIT = 5;
   localparam int USIR_CTRL_TX9_BIT = 6;
   localparam int USIR_CTRL_RX9_BIT = 7;
   localparam int USIR_CTRL_TRANSMIT_NINTH_BIT_VALUE_BIT = 8;
   // baud control register fields
   localparam int USIR_BAUD_MODE16_BIT = 0;
   localparam int USIR_BAUD_INFRARED_ENABLE_BIT = 1;
   localparam int USIR_BAUD_TXPOL_BIT = 2;
   localparam int USIR_BAUD_RXPOL_BIT = 3;
   // status register fields
   localparam int USIR_STAT_TXIF_BIT = 0;
   localparam int USIR_STAT_TRMT_BIT = 1;
   localparam int USIR_STAT_RCIF_BIT = 2;
   localparam int USIR_STAT_OERR_BIT = 3;
   // interrupt enable fields
   localparam int USIR_IRQEN_TX_BIT = 0;
   localparam int USIR_IRQEN_RX_BIT = 1;
   // reset values
   localparam logic [15:0] USIR_BRG_RESET = 16'h0000;
   localparam logic [8:0] USIR_BUF_RESET = 9'h000;
   // frame bit counts, and sub-bit and infrared timing counts in 16x periods
   localparam logic [3:0] USIR_SUB_STEP16 = 4'h1;
   localparam logic [3:0] USIR_SUB_STEP4 = 4'h4;
   localparam logic [3:0] USIR_SUB_LAST16 = 4'hF;
   localparam logic [3:0] USIR_SUB_LAST4 = 4'hC;
   localparam logic [3:0] USIR_IR_PULSE_FIRST = 4'h7;
   localparam logic [3:0] USIR_IR_PULSE_LAST = 4'h9;
   localparam logic [3:0] USIR_IR_HOLD_LAST = 4'hF;
   localparam logic [3:0] USIR_SYNC_BITS8 = 4'h8;
   localparam logic [3:0] USIR_SYNC_BITS9 = 4'h9;
   localparam logic [3:0] USIR_ASYNC_BITS8 = 4'hA;
   localparam logic [3:0] USIR_ASYNC_BITS9 = 4'hB;
endpackage

// File: design/usir_top.sv
// synchronous slave serial port with baud clock output and infrared codec
`timescale 1ns/10ps
`default_nettype none
module usir_top
   import usir_pkg::*;
#(
   parameter int BRG_W = 16
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // low-power state of the chip
   input wire logic sleep_in,
   input wire logic idle_in,
   output logic wake_out,
   // transmit pin, shift clock input in synchronous mode
   input wire logic tx_pin_in,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   // receive pin, data line in synchronous mode
   input wire logic rx_pin_in,
   output logic rx_pin_out,
   output logic rx_pin_oe,
   // baud clock pin
   output logic bclk_out,
   output logic bclk_oe,
   // decoded infrared stream for the asynchronous receiver
   output logic ir_rx_data_out
);
   if (BRG_W < 2 || BRG_W > 16)
   begin : g_bad_width
      $error("BRG_W must lie between 2 and 16");
   end

   typedef struct packed {
      logic serial_port_enable;
      logic sync;
      logic clock_source_select;
      logic continuous_receive_enable;
      logic single_receive_enable;
      logic txen;
      logic tx9;
      logic rx9;
      logic transmit_ninth_bit_value;
      logic mode16;
      logic infrared_enable;
      logic txpol;
      logic rxpol;
      logic txie;
      logic rcie;
      logic [BRG_W-1:0] brg_val;
      logic [BRG_W-1:0] brg_cnt;
      logic [3:0] sub;
      logic bclk;
      logic [7:0] txbuf;
      logic txfull;
      logic [10:0] transmit_shift_reg;
      logic [3:0] tcnt;
      logic tasync;
      logic [8:0] receive_shift_reg;
      logic [3:0] rcnt;
      logic [8:0] rxbuf;
      logic rcif;
      logic oerr;
      logic ck_s1;
      logic ck_s2;
      logic ck_d;
      logic dt_s1;
      logic dt_s2;
      logic [31:0] rdata;
      logic wake;
   } usir_state_s;

   usir_state_s q, n;

   logic sync_slave;
   logic async_en;
   logic bclk_en;
   logic ir_en;
   logic brg_run;
   logic brg_tick;
   logic bit_tick;
   logic ck_fall;
   logic tbusy;
   logic tx_load;
   logic tx_shift;
   logic rx_done;
   logic [8:0] rsr_next;
   logic [8:0] rx_word;
   logic [3:0] sync_bits;
   logic tx_serial;
   logic ir_enc;
   logic ir_dec;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign sync_slave = q.serial_port_enable & q.sync & ~q.clock_source_select;
   assign async_en = q.serial_port_enable & ~q.sync;
   assign bclk_en = async_en & q.clock_source_select;
   assign ir_en = async_en & q.infrared_enable & q.mode16;
   // slave mode never runs the generator: the far end owns the shift clock
   assign brg_run = async_en;
   assign brg_tick = brg_run && q.brg_cnt == '0;
   assign bit_tick = brg_tick
      && q.sub == (q.mode16 ? USIR_SUB_LAST16 : USIR_SUB_LAST4);
   assign ck_fall = q.ck_d & ~q.ck_s2;
   assign tbusy = q.tcnt != 4'h0;
   assign sync_bits = q.tx9 ? USIR_SYNC_BITS9 : USIR_SYNC_BITS8;
   // half duplex: a slave with continuous receive set does not transmit;
   // async words wait for a bit boundary so the start bit is never cut short
   assign tx_load = q.txen & q.txfull & ~tbusy
      & (async_en ? bit_tick : (sync_slave & ~q.continuous_receive_enable));
   assign tx_shift = tbusy & (q.tasync ? bit_tick : ck_fall);
   assign rx_done = sync_slave & q.continuous_receive_enable & ck_fall
      && q.rcnt == (q.rx9 ? USIR_SYNC_BITS9 : USIR_SYNC_BITS8) - 4'h1;
   assign rsr_next = {q.dt_s2, q.receive_shift_reg[8:1]};
   assign rx_word = q.rx9 ? rsr_next : {1'b0, rsr_next[8:1]};
   assign tx_serial = tbusy ? q.transmit_shift_reg[0] : 1'b1;

   always_comb
   begin
      n = q;
      n.ck_s1 = tx_pin_in;
      n.ck_s2 = q.ck_s1;
      n.ck_d = q.ck_s2;
      n.dt_s1 = rx_pin_in;
      n.dt_s2 = q.dt_s1;
      n.rdata = 32'h0000_0000;

      // register writes
      if (wr_in)
      begin
         if (hit(addr_in, USIR_CTRL_OFF))
         begin
            n.serial_port_enable = wdata_in[USIR_CTRL_SERIAL_PORT_ENABLE_BIT];
            n.sync = wdata_in[USIR_CTRL_SYNC_BIT];
            n.clock_source_select = wdata_in[USIR_CTRL_CLOCK_SOURCE_SELECT_BIT];
            n.continuous_receive_enable = wdata_in[USIR_CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT];
            n.single_receive_enable = wdata_in[USIR_CTRL_SINGLE_RECEIVE_ENABLE_BIT];
            n.txen = wdata_in[USIR_CTRL_TXEN_BIT];
            n.tx9 = wdata_in[USIR_CTRL_TX9_BIT];
            n.rx9 = wdata_in[USIR_CTRL_RX9_BIT];
            n.transmit_ninth_bit_value = wdata_in[USIR_CTRL_TRANSMIT_NINTH_BIT_VALUE_BIT];
         end
         if (hit(addr_in, USIR_BAUD_OFF))
         begin
            n.mode16 = wdata_in[USIR_BAUD_MODE16_BIT];
            n.infrared_enable = wdata_in[USIR_BAUD_INFRARED_ENABLE_BIT];
            n.txpol = wdata_in[USIR_BAUD_TXPOL_BIT];
            n.rxpol = wdata_in[USIR_BAUD_RXPOL_BIT];
         end
         if (hit(addr_in, USIR_BRG_OFF))
         begin
            n.brg_val = wdata_in[BRG_W-1:0];
         end
         if (hit(addr_in, USIR_IRQEN_OFF))
         begin
            n.txie = wdata_in[USIR_IRQEN_TX_BIT];
            n.rcie = wdata_in[USIR_IRQEN_RX_BIT];
         end
      end

      // baud generator; the baud clock is high for the upper half of each count
      if (!brg_run)
      begin
         n.brg_cnt = q.brg_val;
         n.sub = 4'h0;
      end
      else if (brg_tick)
      begin
         n.brg_cnt = q.brg_val;
         n.sub = q.sub + (q.mode16 ? USIR_SUB_STEP16 : USIR_SUB_STEP4);
      end
      else
      begin
         n.brg_cnt = q.brg_cnt - 1'b1;
      end
      // odd generator values give an even split, even ones cannot
      n.bclk = bclk_en & ~sleep_in
         & (n.brg_cnt > (q.brg_val >> 1));

      // transmit shift register; sleep changes nothing here, so a second
      // queued word waits in the buffer until the first has gone
      if (tx_shift)
      begin
         n.transmit_shift_reg = {1'b1, q.transmit_shift_reg[10:1]};
         n.tcnt = q.tcnt - 4'h1;
      end
      if (!q.serial_port_enable || !q.txen)
      begin
         n.tcnt = 4'h0;
      end
      if (tx_load)
      begin
         n.tasync = async_en;
         n.txfull = 1'b0;
         if (async_en)
         begin
            n.transmit_shift_reg = {1'b1, q.tx9 ? q.transmit_ninth_bit_value : 1'b1, q.txbuf, 1'b0};
            n.tcnt = q.tx9 ? USIR_ASYNC_BITS9 : USIR_ASYNC_BITS8;
         end
         else
         begin
            n.transmit_shift_reg = {2'b11, q.transmit_ninth_bit_value, q.txbuf};
            n.tcnt = sync_bits;
         end
      end
      // a write in the same cycle as a transfer leaves the buffer full
      if (wr_in && hit(addr_in, USIR_TXDATA_OFF))
      begin
         n.txbuf = wdata_in[7:0];
         n.txfull = 1'b1;
      end

      // synchronous slave reception, sampled on the falling shift clock
      if (sync_slave && q.continuous_receive_enable && ck_fall)
      begin
         n.receive_shift_reg = rsr_next;
         n.rcnt = rx_done ? 4'h0 : q.rcnt + 4'h1;
      end
      if (rd_in && hit(addr_in, USIR_RXDATA_OFF))
      begin
         n.rcif = 1'b0;
      end
      if (rx_done)
      begin
         // an unread word is kept; the new one is lost and flagged
         if (q.rcif)
         begin
            n.oerr = 1'b1;
         end
         else
         begin
            n.rxbuf = rx_word;
         end
         n.rcif = 1'b1;
      end
      if (!q.continuous_receive_enable)
      begin
         n.oerr = 1'b0;
         n.rcnt = 4'h0;
      end

      // register reads
      if (rd_in)
      begin
         if (hit(addr_in, USIR_CTRL_OFF))
         begin
            n.rdata[USIR_CTRL_SERIAL_PORT_ENABLE_BIT] = q.serial_port_enable;
            n.rdata[USIR_CTRL_SYNC_BIT] = q.sync;
            n.rdata[USIR_CTRL_CLOCK_SOURCE_SELECT_BIT] = q.clock_source_select;
            n.rdata[USIR_CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT] = q.continuous_receive_enable;
            n.rdata[USIR_CTRL_SINGLE_RECEIVE_ENABLE_BIT] = q.single_receive_enable;
            n.rdata[USIR_CTRL_TXEN_BIT] = q.txen;
            n.rdata[USIR_CTRL_TX9_BIT] = q.tx9;
            n.rdata[USIR_CTRL_RX9_BIT] = q.rx9;
            n.rdata[USIR_CTRL_TRANSMIT_NINTH_BIT_VALUE_BIT] = q.transmit_ninth_bit_value;
         end
         if (hit(addr_in, USIR_BAUD_OFF))
         begin
            n.rdata[USIR_BAUD_MODE16_BIT] = q.mode16;
            n.rdata[USIR_BAUD_INFRARED_ENABLE_BIT] = q.infrared_enable;
            n.rdata[USIR_BAUD_TXPOL_BIT] = q.txpol;
            n.rdata[USIR_BAUD_RXPOL_BIT] = q.rxpol;
         end
         if (hit(addr_in, USIR_BRG_OFF))
         begin
            n.rdata[BRG_W-1:0] = q.brg_val;
         end
         if (hit(addr_in, USIR_TXDATA_OFF))
         begin
            n.rdata[7:0] = q.txbuf;
         end
         if (hit(addr_in, USIR_RXDATA_OFF))
         begin
            n.rdata[8:0] = q.rxbuf;
         end
         if (hit(addr_in, USIR_STATUS_OFF))
         begin
            n.rdata[USIR_STAT_TXIF_BIT] = ~q.txfull;
            n.rdata[USIR_STAT_TRMT_BIT] = ~tbusy;
            n.rdata[USIR_STAT_RCIF_BIT] = q.rcif;
            n.rdata[USIR_STAT_OERR_BIT] = q.oerr;
         end
         if (hit(addr_in, USIR_IRQEN_OFF))
         begin
            n.rdata[USIR_IRQEN_TX_BIT] = q.txie;
            n.rdata[USIR_IRQEN_RX_BIT] = q.rcie;
         end
      end

      // wake request while the chip is in a low-power state
      n.wake = (sleep_in | idle_in)
         & ((~q.txfull & q.txie) | (q.rcif & q.rcie));
   end

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         q <= '0;
         q.brg_val <= USIR_BRG_RESET[BRG_W-1:0];
         q.brg_cnt <= USIR_BRG_RESET[BRG_W-1:0];
         q.rxbuf <= USIR_BUF_RESET;
         q.transmit_shift_reg <= '1;
         q.ck_s1 <= 1'b1;
         q.ck_s2 <= 1'b1;
         q.ck_d <= 1'b1;
         q.dt_s1 <= 1'b1;
         q.dt_s2 <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

   usir_ir_codec u_codec (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .enable_in(ir_en),
      .tick16_in(brg_tick),
      .phase_in(q.sub),
      .enc_bit_in(tx_serial),
      .tx_pol_in(q.txpol),
      .enc_out(ir_enc),
      .rx_in(q.dt_s2),
      .rx_pol_in(q.rxpol),
      .dec_out(ir_dec)
   );

   // pins: slave takes the clock on the transmit pin, data on the receive pin
   assign tx_pin_oe = async_en;
   assign tx_pin_out = ir_en ? ir_enc : tx_serial;
   assign rx_pin_oe = sync_slave & q.txen & ~q.continuous_receive_enable;
   assign rx_pin_out = tx_serial;
   assign bclk_oe = bclk_en;
   assign bclk_out = q.bclk;
   assign ir_rx_data_out = ir_dec;
   assign rdata_out = q.rdata;
   assign wake_out = q.wake;
endmodule // usir_top
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the serial block
`timescale 1ns/10ps
`default_nettype none
module testbench import usir_pkg::*;;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] SER_EN = ONE << USIR_CTRL_SERIAL_PORT_ENABLE_BIT;
   localparam logic [31:0] SYNC_SEL = ONE << USIR_CTRL_SYNC_BIT;
   localparam logic [31:0] CLK_SRC = ONE << USIR_CTRL_CLOCK_SOURCE_SELECT_BIT;
   localparam logic [31:0] CONT_RX = ONE << USIR_CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT;
   localparam logic [31:0] ONE_RX = ONE << USIR_CTRL_SINGLE_RECEIVE_ENABLE_BIT;
   localparam logic [31:0] TX_EN = ONE << USIR_CTRL_TXEN_BIT;
   localparam logic [31:0] MODE16 = ONE << USIR_BAUD_MODE16_BIT;
   localparam logic [31:0] IR_EN = ONE << USIR_BAUD_INFRARED_ENABLE_BIT;
   localparam logic [31:0] TX_POL = ONE << USIR_BAUD_TXPOL_BIT;
   localparam logic [31:0] RX_POL = ONE << USIR_BAUD_RXPOL_BIT;
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic sleep_in = 1'b0;
   logic idle_in = 1'b0;
   logic [31:0] rdata_out;
   logic wake_out, tx_pin_in, tx_pin_out, tx_pin_oe, rx_pin_in, rx_pin_out, rx_pin_oe;
   logic bclk_out, bclk_oe, ir_rx_data_out;
   logic [31:0] seed = 32'hac55_14a9;
   logic [31:0] rv;
   logic [7:0] got;
   logic [7:0] q[$];
   int fails = 0;
   int num_checks = 0;
   int hi, lo, n;
   always #10 core_clk_in = ~core_clk_in;
   usir_top u_usir_top (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .sleep_in(sleep_in), .idle_in(idle_in), .wake_out(wake_out), .tx_pin_in(tx_pin_in),
      .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in),
      .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .bclk_out(bclk_out),
      .bclk_oe(bclk_oe), .ir_rx_data_out(ir_rx_data_out));
   usir_partner u_usir_partner (.core_clk_in(core_clk_in), .dev_out_in(rx_pin_out),
      .dev_oe_in(rx_pin_oe), .sck_out(tx_pin_in), .line_out(rx_pin_in));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int a, input int b, input int g);
      num_checks++;
      if (g < a || g > b)
      begin
         fails++;
         $display("unexpected %s expected %0d..%0d seen %0d", nm, a, b, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      @(negedge core_clk_in);
      rv = rdata_out;
      if (e !== 32'hFFFF_FFFF)
         chk(nm, e, rv);
   endtask
   task automatic st(input int b, input logic e, input string nm);
      rc(USIR_STATUS_OFF, 32'hFFFF_FFFF, nm);
      chk(nm, 32'(e), 32'(rv[b]));
   endtask
   // counts settled cycles at one level, bounded against a stuck pin
   task automatic span(input logic v, output int c);
      c = 0;
      while (bclk_out === v && c < 200)
      begin
         @(negedge core_clk_in);
         c++;
      end
   endtask
   initial
   begin
      repeat (40000) @(posedge core_clk_in);
      fails++;
      end_of_test;
   end
   initial
   begin
      repeat (5) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      rc(USIR_CTRL_OFF, 32'h0000_0000, "ctrl reset");
      rc(USIR_BRG_OFF, 32'(USIR_BRG_RESET), "rate reset");
      wr(8'h1C, 32'hFFFF_FFFF);
      rc(8'h1C, 32'h0000_0000, "unmapped");
      // slave transmit, two words queued before sleep
      wr(USIR_IRQEN_OFF, ONE << USIR_IRQEN_TX_BIT);
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL | TX_EN);
      for (int i = 0; i < 2; i++)
      begin
         seed = lfsr(seed);
         q.push_back(seed[7:0]);
         wr(USIR_TXDATA_OFF, 32'(seed[7:0]));
         repeat (3) @(posedge core_clk_in);
      end
      sleep_in <= 1'b1;
      st(USIR_STAT_TXIF_BIT, 1'b0, "flag held in sleep");
      u_usir_partner.frame(8'hFF, got);
      chk("slave word one", 32'(q.pop_front()), 32'(got));
      repeat (4) @(posedge core_clk_in);
      st(USIR_STAT_TXIF_BIT, 1'b1, "flag after reload");
      chk("wake on transmit", ONE, 32'(wake_out));
      wr(USIR_STATUS_OFF, 32'h0000_0000);
      st(USIR_STAT_TXIF_BIT, 1'b1, "flag not cleared by write");
      u_usir_partner.frame(8'hFF, got);
      chk("slave word two", 32'(q.pop_front()), 32'(got));
      sleep_in <= 1'b0;
      // slave receive: single enable ignored, continuous works in idle
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL | ONE_RX);
      u_usir_partner.frame(8'h5A, got);
      st(USIR_STAT_RCIF_BIT, 1'b0, "single enable ignored");
      wr(USIR_IRQEN_OFF, ONE << USIR_IRQEN_RX_BIT);
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL | CONT_RX);
      idle_in <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         seed = lfsr(seed);
         q.push_back(seed[7:0]);
         u_usir_partner.frame(seed[7:0], got);
      end
      repeat (4) @(negedge core_clk_in);
      chk("wake on receive", ONE, 32'(wake_out));
      st(USIR_STAT_RCIF_BIT, 1'b1, "receive flag");
      st(USIR_STAT_OERR_BIT, 1'b1, "overrun");
      rc(USIR_RXDATA_OFF, 32'(q.pop_front()), "received word");
      q.delete();
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL);
      st(USIR_STAT_OERR_BIT, 1'b0, "overrun cleared");
      @(posedge core_clk_in);
      idle_in <= 1'b0;
      // baud clock output, both rate modes, even and odd divisors
      wr(USIR_CTRL_OFF, SER_EN | CLK_SRC);
      for (int m = 0; m < 2; m++)
         for (int b = 4; b < 6; b++)
         begin
            wr(USIR_BAUD_OFF, m ? MODE16 : 32'h0000_0000);
            wr(USIR_BRG_OFF, 32'(b));
            repeat (20) @(negedge core_clk_in);
            span(1'b1, n);
            span(1'b0, n);
            span(1'b1, hi);
            span(1'b0, lo);
            chk("baud clock high", 32'(b - b / 2), 32'(hi));
            chk("baud clock period", 32'(b + 1), 32'(hi + lo));
         end
      chk("baud pin driven", ONE, 32'(bclk_oe));
      @(posedge core_clk_in);
      sleep_in <= 1'b1;
      repeat (3) @(negedge core_clk_in);
      chk("baud clock in sleep", 32'h0000_0000, 32'(bclk_out));
      @(posedge core_clk_in);
      sleep_in <= 1'b0;
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL | CLK_SRC);
      @(negedge core_clk_in);
      chk("baud pin in sync", 32'h0000_0000, 32'(bclk_oe));
      // infrared encoder, both transmit polarities, byte 0x0f
      for (int p = 0; p < 2; p++)
      begin
         wr(USIR_CTRL_OFF, SER_EN | TX_EN);
         wr(USIR_BAUD_OFF, MODE16 | IR_EN | (p ? TX_POL : RX_POL));
         wr(USIR_BRG_OFF, 32'(1));
         repeat (4) @(negedge core_clk_in);
         chk("encoder idle", 32'(p), 32'(tx_pin_out));
         wr(USIR_TXDATA_OFF, 32'h0000_000F);
         n = 0;
         repeat (360)
         begin
            @(negedge core_clk_in);
            if (tx_pin_out !== 1'(p))
               n++;
         end
         chk("encoded pulse time", 32'(5 * 3 * 2), 32'(n));
      end
      wr(USIR_BAUD_OFF, IR_EN);
      repeat (4) @(negedge core_clk_in);
      chk("no encoding in 4x", ONE, 32'(tx_pin_out));
      wr(USIR_CTRL_OFF, SER_EN | SYNC_SEL);
      wr(USIR_BAUD_OFF, MODE16 | IR_EN);
      repeat (4) @(negedge core_clk_in);
      chk("no infrared in sync", ONE, 32'(ir_rx_data_out));
      // decoder: one pulse, then two overlapping, both receive polarities
      wr(USIR_CTRL_OFF, SER_EN | CONT_RX);
      for (int p = 0; p < 2; p++)
      begin
         wr(USIR_BAUD_OFF, MODE16 | IR_EN | (p ? RX_POL : 32'h0000_0000));
         u_usir_partner.ir_idle(1'(1 - p));
         repeat (80) @(negedge core_clk_in);
         u_usir_partner.ir_pulse(1'(1 - p), 6);
         if (p == 1)
         begin
            repeat (14) @(posedge core_clk_in);
            u_usir_partner.ir_pulse(1'(1 - p), 6);
         end
         @(negedge core_clk_in);
         n = 0;
         while (ir_rx_data_out === 1'b0 && n < 200)
         begin
            @(negedge core_clk_in);
            n++;
         end
         chk_rng("decoded low", 32 * (p + 1) - 2, 32 * (p + 1) + 2, n + 5 + 20 * p);
      end
      end_of_test;
   end
endmodule // testbench
`default_nettype wire

// File: verif/usir_checker.sv
// port-level assertions for the serial block
`timescale 1ns/10ps
`default_nettype none
module usir_checker
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // register port
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // power state
   input wire logic sleep_in,
   input wire logic idle_in,
   input wire logic wake_out,
   // pins
   input wire logic tx_pin_in,
   input wire logic tx_pin_oe,
   input wire logic rx_pin_out,
   input wire logic rx_pin_oe,
   input wire logic bclk_out,
   input wire logic bclk_oe,
   input wire logic ir_rx_data_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // shift clock parked high and no buffer write: nothing may shift or load
   sequence s_quiet;
      (rx_pin_oe && tx_pin_in && !wr_in) [*6];
   endsequence
   sequence s_dec_low;
      (!ir_rx_data_out) [*8];
   endsequence
   AST_SLV_HOLD: assert property (s_quiet |-> $stable(rx_pin_out))
      else $error("slave data moved without a shift clock edge");
   AST_PIN_EXCL: assert property (rx_pin_oe |-> !tx_pin_oe && !bclk_oe)
      else $error("slave drives a clock pin");
   AST_BCLK_SLEEP: assert property (sleep_in ##1 sleep_in |-> !bclk_out)
      else $error("baud clock high in sleep");
   AST_BCLK_OFF: assert property (!bclk_oe ##1 !bclk_oe |-> !bclk_out)
      else $error("baud clock high while pin not driven");
   AST_BCLK_RISE: assert property ($rose(bclk_out) |-> $past(bclk_oe))
      else $error("baud clock rose while disabled");
   AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
      else $error("read data outside its cycle");
   AST_WAKE_LP: assert property (!(sleep_in || idle_in) |=> !wake_out)
      else $error("wake request while running");
   AST_DEC_HOLD: assert property ($fell(ir_rx_data_out) |-> s_dec_low)
      else $error("decoded low too short");
endmodule // usir_checker

bind usir_top usir_checker u_usir_checker (
   .core_clk_in(core_clk_in),
   .resetn_in(resetn_in),
   .wr_in(wr_in),
   .rd_in(rd_in),
   .rdata_out(rdata_out),
   .sleep_in(sleep_in),
   .idle_in(idle_in),
   .wake_out(wake_out),
   .tx_pin_in(tx_pin_in),
   .tx_pin_oe(tx_pin_oe),
   .rx_pin_out(rx_pin_out),
   .rx_pin_oe(rx_pin_oe),
   .bclk_out(bclk_out),
   .bclk_oe(bclk_oe),
   .ir_rx_data_out(ir_rx_data_out)
);
`default_nettype wire

// File: verif/usir_partner.sv
// far side: external shift-clock master and infrared transceiver
`timescale 1ns/10ps
`default_nettype none
module usir_partner
(
   // clock
   input wire logic core_clk_in,
   // device data pin
   input wire logic dev_out_in,
   input wire logic dev_oe_in,
   // master lines
   output logic sck_out,
   output logic line_out
);
   localparam int HALF = 12;
   logic sck = 1'b1;
   logic drv = 1'b0;
   logic dat = 1'b1;
   logic flip = 1'b0;
   always @(posedge core_clk_in) flip <= ~flip;
   assign sck_out = sck;
   // released line toggles so a stale bit is never read back
   assign line_out = dev_oe_in ? dev_out_in : (drv ? dat : flip);
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge core_clk_in);
         drv <= 1'b1;
         dat <= tx[i];
         repeat (HALF) @(posedge core_clk_in);
         rx[i] = line_out;
         sck <= 1'b0;
         repeat (HALF) @(posedge core_clk_in);
         sck <= 1'b1;
      end
      repeat (HALF) @(posedge core_clk_in);
      drv <= 1'b0;
   endtask
   task automatic ir_idle(input logic lvl);
      @(posedge core_clk_in);
      drv <= 1'b1;
      dat <= lvl;
   endtask
   task automatic ir_pulse(input logic lvl, input int w);
      @(posedge core_clk_in);
      dat <= ~lvl;
      repeat (w) @(posedge core_clk_in);
      dat <= lvl;
   endtask
endmodule // usir_partner
`default_nettype wire
